// File: adcs_map.svh
// Constants for the converter data-channel sequencer: field positions,
// widths and depths. Assumes bit 0 of a bus word is its MSB, so word bit n
// sits at vector index 17-n.
//
// =====================================================================
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH

// =====================================================================
// Word layout
`define ADCS_WORD_W     18
`define ADCS_DATA_W     12
`define ADCS_GAIN_W     2
`define ADCS_PAD_W      4
`define ADCS_CTL_W      5
`define ADCS_CHAN_W     7

// =====================================================================
// Control bit positions (vector index) in input and output status words
`define ADCS_ISW_DCH    11
`define ADCS_ISW_RAND   10
`define ADCS_OSW_WC     13

// =====================================================================
// Buffer sizing
`define ADCS_FIFO_DEPTH 16

`endif

// File: adcs_pkg.sv
// Types shared by the sequencer, its host model and its bench.
// Assumes the constant header sits in the same folder.
`include "adcs_map.svh"

package adcs_pkg;

    typedef logic [`ADCS_WORD_W-1:0] adcs_word_t;

    // Input status word, MSB first: gain, unused, control, channel
    typedef struct packed {
        logic [`ADCS_GAIN_W-1:0] gain;
        logic [`ADCS_PAD_W-1:0]  pad;
        logic [`ADCS_CTL_W-1:0]  ctl;
        logic [`ADCS_CHAN_W-1:0] chan;
    } adcs_status_t;

    typedef enum logic [1:0] {
        ADCS_ST_IDLE  = 2'b00,
        ADCS_ST_CONV  = 2'b01,
        ADCS_ST_FETCH = 2'b10,
        ADCS_ST_STORE = 2'b11
    } adcs_state_t;

endpackage

// File: adcs_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps

module adcs_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    // =================================================================
    // Elaboration check: pointer wrap needs a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("adcs_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    // =================================================================
    // Full when pointers differ only in the wrap bit
    assign in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    // Storage has no reset; only the pointers matter
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointer update
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end

endmodule

// File: adcs_seq.sv
// Data-channel sequencer for the converter subsystem: accepts start and
// skip commands, drives the converter, and asks the host for break cycles
// to fetch status words and store converted words.
// Assumes host bus and converter logic run on clk; commands, grants and
// converter done are one-cycle pulses from that logic.
`timescale 1ns/1ps
`include "adcs_map.svh"

module adcs_seq #(
    parameter int FIFO_DEPTH = `ADCS_FIFO_DEPTH
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        start_convert_cmd,
    input  wire logic                        skip_on_count_overflow_cmd,
    input  wire adcs_pkg::adcs_word_t        acc_word,
    input  wire logic                        data_channel_break,
    input  wire logic                        count_overflow_signal,
    input  wire adcs_pkg::adcs_word_t        dch_rdata,
    input  wire logic                        prog_int_en,
    input  wire logic                        api_int_en,
    input  wire logic                        conv_done,
    input  wire logic [`ADCS_DATA_W-1:0]     conv_data,
    output logic                             dch_req,
    output logic                             dch_store,
    output adcs_pkg::adcs_word_t             dch_wdata,
    output logic                             skip_out,
    output adcs_pkg::adcs_word_t             status_word,
    output logic                             prog_int_req,
    output logic                             api_int_req,
    output logic                             done_flag,
    output logic                             conv_start,
    output logic [`ADCS_CHAN_W-1:0]          conv_chan,
    output logic [`ADCS_GAIN_W-1:0]          conv_gain
);
    import adcs_pkg::*;

    localparam int CTL_DCH  = `ADCS_ISW_DCH - `ADCS_CHAN_W;
    localparam int CTL_RAND = `ADCS_ISW_RAND - `ADCS_CHAN_W;

    // =================================================================
    // Registers
    adcs_state_t  state_reg,    state_next;
    adcs_status_t status_reg,   status_next;
    logic         wc_flag_reg,  wc_flag_next;
    logic         done_reg,     done_next;
    logic         req_reg,      req_next;
    logic         store_reg;
    logic         skip_reg;
    logic         pint_reg;
    logic         aint_reg;
    logic         cstart_reg;
    adcs_word_t   wdata_reg;
    adcs_word_t   osw_reg;

    // =================================================================
    // Decode
    logic         mode_dch;
    logic         mode_rand;
    logic         acc_rand;
    logic         grant;
    logic         grant_store;
    logic         grant_fetch;
    logic         conv_end;
    logic         start_conv;
    logic         seq_next;
    logic         fifo_in_ready;
    logic         fifo_out_valid;
    adcs_word_t   fifo_out_data;
    adcs_word_t   conv_word;

    assign mode_dch    = status_reg.ctl[CTL_DCH];
    assign mode_rand   = status_reg.ctl[CTL_RAND] & mode_dch;
    assign acc_rand    = acc_word[`ADCS_ISW_DCH] & acc_word[`ADCS_ISW_RAND];
    assign grant       = data_channel_break & req_reg;
    assign grant_store = grant & store_reg;
    assign grant_fetch = grant & ~store_reg;
    assign conv_end    = conv_done & (state_reg == ADCS_ST_CONV);
    // Sign extension of the converted word into the upper bits
    assign conv_word   = {{(`ADCS_WORD_W-`ADCS_DATA_W){conv_data[11]}},
                          conv_data};

    // Sequential store granted: step to the following channel
    assign seq_next    = (state_reg == ADCS_ST_STORE) & grant_store
                       & ~mode_rand & ~count_overflow_signal
                       & fifo_in_ready;

    // Converter starts: direct start, after a store, after a fetch.
    // A full buffer holds off the next sequential conversion.
    assign start_conv =
        (start_convert_cmd & ~acc_rand)
        | seq_next
        | (state_reg == ADCS_ST_FETCH & grant_fetch
           & ~count_overflow_signal);

    // =================================================================
    // Converted words wait here until the host grants a store break
    adcs_fifo #(
        .WIDTH (`ADCS_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (conv_end & mode_dch),
        .in_ready  (fifo_in_ready),
        .in_data   (conv_word),
        .out_valid (fifo_out_valid),
        .out_ready (grant_store),
        .out_data  (fifo_out_data)
    );

    // =================================================================
    // Sequencer state
    always_comb begin
        state_next = state_reg;
        if (start_convert_cmd) begin
            state_next = acc_rand ? ADCS_ST_FETCH : ADCS_ST_CONV;
        end else if (count_overflow_signal & mode_dch) begin
            state_next = ADCS_ST_IDLE;
        end else begin
            case (state_reg)
                ADCS_ST_IDLE: state_next = ADCS_ST_IDLE;
                ADCS_ST_CONV: begin
                    if (conv_done) begin
                        state_next = mode_dch ? ADCS_ST_STORE
                                              : ADCS_ST_IDLE;
                    end
                end
                ADCS_ST_FETCH: begin
                    if (grant_fetch) begin
                        state_next = ADCS_ST_CONV;
                    end
                end
                ADCS_ST_STORE: begin
                    if (grant_store & mode_rand) begin
                        state_next = ADCS_ST_FETCH;
                    end else if (start_conv) begin
                        state_next = ADCS_ST_CONV;
                    end
                end
                default: state_next = ADCS_ST_IDLE;
            endcase
        end
    end

    // Status word: random start takes only the mode bits
    always_comb begin
        status_next = status_reg;
        if (start_convert_cmd & acc_rand) begin
            status_next.ctl[CTL_DCH]  = 1'b1;
            status_next.ctl[CTL_RAND] = 1'b1;
        end else if (start_convert_cmd) begin
            status_next = adcs_status_t'(acc_word);
        end else if (grant_fetch) begin
            status_next = adcs_status_t'(dch_rdata);
        end else if (seq_next) begin
            // Channel address wraps from the top back to zero
            status_next.chan = status_reg.chan + 7'h01;
        end
    end

    // Flags: a set arriving with the start command wins over the clear
    assign wc_flag_next = count_overflow_signal
                        | (wc_flag_reg & ~start_convert_cmd);
    assign done_next    = conv_end
                        | (done_reg & ~start_convert_cmd);

    // One request at a time; it falls the cycle after the grant
    always_comb begin
        req_next = 1'b0;
        if (grant | wc_flag_reg | count_overflow_signal) begin
            req_next = 1'b0;
        end else if (state_reg == ADCS_ST_STORE) begin
            req_next = fifo_out_valid;
        end else if (state_reg == ADCS_ST_FETCH) begin
            req_next = 1'b1;
        end
    end

    // =================================================================
    // State and control flops
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg   <= ADCS_ST_IDLE;
            status_reg  <= '0;
            wc_flag_reg <= 1'b0;
            done_reg    <= 1'b0;
            req_reg     <= 1'b0;
            store_reg   <= 1'b0;
            cstart_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            status_reg  <= status_next;
            wc_flag_reg <= wc_flag_next;
            done_reg    <= done_next;
            req_reg     <= req_next;
            store_reg   <= (state_reg == ADCS_ST_STORE);
            cstart_reg  <= start_conv;
        end
    end

    // Host-facing outputs, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            skip_reg  <= 1'b0;
            pint_reg  <= 1'b0;
            aint_reg  <= 1'b0;
            wdata_reg <= '0;
            osw_reg   <= '0;
        end else begin
            skip_reg  <= skip_on_count_overflow_cmd & wc_flag_reg;
            pint_reg  <= wc_flag_reg & prog_int_en;
            aint_reg  <= wc_flag_reg & api_int_en;
            wdata_reg <= fifo_out_data;
            osw_reg   <= {4'h0, wc_flag_reg, 6'h00,
                          status_reg.chan};
        end
    end

    assign dch_req      = req_reg;
    assign dch_store    = store_reg;
    assign dch_wdata    = wdata_reg;
    assign skip_out     = skip_reg;
    assign status_word  = osw_reg;
    assign prog_int_req = pint_reg;
    assign api_int_req  = aint_reg;
    assign done_flag    = done_reg;
    assign conv_start   = cstart_reg;
    assign conv_chan    = status_reg.chan;
    assign conv_gain    = status_reg.gain;

    // =================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_conv_push;
        conv_end && mode_dch && !start_convert_cmd
            && !count_overflow_signal && !wc_flag_reg;
    endsequence

    sequence s_quiet;
        !count_overflow_signal && !start_convert_cmd && !wc_flag_reg;
    endsequence

    sequence s_rand_start;
        start_convert_cmd && acc_rand && !count_overflow_signal;
    endsequence

    a_start_clears_done: assert property (
        start_convert_cmd && !conv_end |=> !done_flag)
        else $error("done flag not cleared by start");

    a_done_raises_req: assert property (
        s_conv_push ##1 s_quiet |=> dch_req && dch_store && done_flag)
        else $error("no store request after conversion");

    a_random_fetch: assert property (
        s_rand_start ##1 s_quiet |=> dch_req && !dch_store)
        else $error("no fetch request after random start");

    a_grant_drops_req: assert property (
        dch_req && data_channel_break |=> !dch_req)
        else $error("request held after grant");

    a_ovf_sets_flag: assert property (
        count_overflow_signal |=> wc_flag_reg)
        else $error("count flag not set by overflow");

    a_flag_holds: assert property (
        wc_flag_reg && !start_convert_cmd |=> wc_flag_reg)
        else $error("count flag dropped without start");

    a_int_on_flag: assert property (
        count_overflow_signal && prog_int_en |=> ##1
        (prog_int_req == $past(prog_int_en)))
        else $error("program interrupt not raised");

    a_skip_on_flag: assert property (
        skip_on_count_overflow_cmd |=> skip_out == $past(wc_flag_reg))
        else $error("skip does not follow count flag");

    a_stop_after_ovf: assert property (
        count_overflow_signal |=> !dch_req)
        else $error("request raised after overflow");

    a_status_bit: assert property (
        count_overflow_signal |=> ##1 status_word[`ADCS_OSW_WC])
        else $error("status bit 4 misses count flag");

    a_sign_extend: assert property (
        dch_req && dch_store |-> dch_wdata[17:11] == 7'h00
            || dch_wdata[17:11] == 7'h7f)
        else $error("data word not sign extended");

endmodule

// File: adcs_host_model.sv
// Host data-channel stand-in: grants break cycles, keeps the word counts
// and current addresses of the status and data tables, flags overflow.
// Assumes the sequencer's registered request and the bench's clock.
`timescale 1ns/1ps

module adcs_host_model (
    input  wire logic                 clk,
    input  wire logic                 dch_req,
    input  wire logic                 dch_store,
    input  wire adcs_pkg::adcs_word_t dch_wdata,
    input  wire logic [3:0]           gdly,
    output logic                      brk,
    output adcs_pkg::adcs_word_t      rdata,
    output logic                      ovf
);
    import adcs_pkg::*;

    // =================================================================
    // Tables and count/address pairs; the status table and the pairs are preloaded by the bench
    adcs_word_t stat_mem [0:63];
    adcs_word_t data_mem [0:63];
    adcs_word_t stat_wc, stat_ca, data_wc, data_ca;
    logic       kinds [$];
    logic [3:0] wait_cnt;
    logic       ovf_due;

    initial begin
        brk = 1'b0;
        ovf = 1'b0;
        ovf_due = 1'b0;
        wait_cnt = 4'h0;
        rdata = '0;
    end

    // Moves on the falling edge, half a cycle away from the sampling edge
    always @(negedge clk) begin
        ovf <= ovf_due;
        ovf_due <= 1'b0;
        if (brk) begin
            brk <= 1'b0;
            rdata <= ~rdata; // Released bus must not keep the last word
        end else if (dch_req === 1'b1) begin
            if (wait_cnt < gdly) begin
                wait_cnt <= wait_cnt + 4'h1; // Slow grants
            end else begin
                wait_cnt <= 4'h0;
                brk <= 1'b1;
                kinds.push_back(dch_store);
                if (dch_store) begin
                    data_wc = data_wc + 18'h1;
                    data_ca = data_ca + 18'h1;
                    data_mem[data_ca[5:0]] = dch_wdata;
                    ovf_due <= (data_wc == '0);
                end else begin
                    stat_wc = stat_wc + 18'h1;
                    stat_ca = stat_ca + 18'h1;
                    rdata <= stat_mem[stat_ca[5:0]];
                end
            end
        end else begin
            rdata <= ~rdata; // Idle bus toggles so no stale word looks valid
        end
    end
endmodule

// File: test_adc_data_channel_sequencer.sv
// Self-checking bench for the sequencer: host model on the break link,
// a converter stand-in, sequential and random runs to count overflow.
// Assumes the package, header and model sit in the same folder.
`timescale 1ns/1ps
`include "adcs_map.svh"

module test_adc_data_channel_sequencer;
    import adcs_pkg::*;

    // =================================================================
    // Signals and bookkeeping
    logic                     clk, rst, start, skip, pen, aen, cdone;
    logic                     brk, ovf, dch_req, dch_store, skip_out;
    logic                     prog_int_req, api_int_req, done_flag;
    logic                     conv_start, ovf_seen, brk_d;
    adcs_word_t               acc, rdata, wdata, status_word;
    logic [`ADCS_DATA_W-1:0]  cdata;
    logic [`ADCS_CHAN_W-1:0]  conv_chan;
    logic [`ADCS_GAIN_W-1:0]  conv_gain;
    logic [3:0]               gdly;
    logic [8:0]               sel_q [$];
    adcs_word_t               exp_q [$];
    int                       n_mismatch, checks_done, seed, k;

    adcs_seq i_dut (.clk(clk), .rst(rst), .start_convert_cmd(start),
        .skip_on_count_overflow_cmd(skip), .acc_word(acc),
        .data_channel_break(brk), .count_overflow_signal(ovf),
        .dch_rdata(rdata), .prog_int_en(pen), .api_int_en(aen),
        .conv_done(cdone), .conv_data(cdata), .dch_req(dch_req),
        .dch_store(dch_store), .dch_wdata(wdata), .skip_out(skip_out),
        .status_word(status_word), .prog_int_req(prog_int_req),
        .api_int_req(api_int_req), .done_flag(done_flag),
        .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_gain(conv_gain));

    adcs_host_model m (.clk(clk), .dch_req(dch_req), .dch_store(dch_store),
        .dch_wdata(wdata), .gdly(gdly), .brk(brk), .rdata(rdata),
        .ovf(ovf));

    always #12.5 clk = ~clk;

    // =================================================================
    // Checking, expectations and closing
    task automatic chk(string what, logic [17:0] seen, logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [8:0] sel(adcs_word_t w);
        return {w[17:16], w[6:0]};
    endfunction

    task automatic test_done();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Overflow seen, and grant edges for the request-drop check
    always @(posedge clk) begin
        if (ovf) ovf_seen <= 1'b1;
        brk_d <= brk & dch_req;
    end

    always @(negedge clk) begin
        if (brk_d) chk("request drop", dch_req, 0);
    end

    // Converter stand-in; a cancelled conversion may still report done
    initial forever begin
        @(negedge clk);
        if (conv_start === 1'b1) begin
            sel_q.push_back({conv_gain, conv_chan});
            repeat (2 + ($random(seed) & 7)) @(negedge clk);
            cdata = 12'($random(seed));
            cdone = 1'b1;
            exp_q.push_back({{6{cdata[11]}}, cdata});
            @(negedge clk);
            cdone = 1'b0;
            if (!ovf_seen) chk("done flag", done_flag, 1);
        end
    end

    // =================================================================
    // Command and run tasks
    task automatic do_reset();
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        chk("reset out", {dch_req, done_flag, conv_start}, 0);
        chk("reset status", status_word, 0);
        rst = 1'b0;
        ovf_seen = 1'b0;
        m.kinds.delete();
        sel_q.delete();
        exp_q.delete();
    endtask

    task automatic start_cmd(adcs_word_t w);
        logic r;
        r = w[`ADCS_ISW_RAND];
        @(negedge clk);
        acc = w;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        acc = ~w; // Accumulator is only meaningful with the command
        chk("conv start", conv_start, !r);
        chk("done clear", done_flag, 0);
        chk("start sel", sel(w) & {9{!r}}, {conv_gain, conv_chan});
    endtask

    task automatic skip_cmd(logic e);
        @(negedge clk);
        skip = 1'b1;
        @(negedge clk);
        skip = 1'b0;
        chk("skip", skip_out, e);
    endtask

    task automatic run(logic rnd, int n, logic [6:0] ch);
        adcs_status_t sw;
        int i;
        do_reset();
        {pen, aen, gdly} = 6'($random(seed));
        m.data_wc = 18'(-n);
        m.data_ca = '1;
        m.stat_wc = 18'(-(n + 1));
        m.stat_ca = '1;
        for (i = 0; i < n; i++) begin
            sw = 18'($random(seed));
            sw.ctl = 5'h18;
            m.stat_mem[i] = sw;
        end
        sw.ctl = rnd ? 5'h18 : 5'h10;
        sw.chan = ch;
        start_cmd(sw);
        skip_cmd(1'b0);
        for (i = 0; i < 4000 && !ovf_seen; i++) @(negedge clk);
        repeat (3) @(negedge clk);
        chk("prog int", prog_int_req, pen);
        chk("api int", api_int_req, aen);
        chk("count flag", status_word[`ADCS_OSW_WC], 1);
        skip_cmd(1'b1);
        repeat (40) @(negedge clk);
        chk("no request", dch_req, 0);
        chk("transfers", m.kinds.size(), rnd ? 2 * n : n);
        for (i = 0; i < m.kinds.size(); i++) begin
            chk("kind", m.kinds[i], rnd ? i[0] : 1'b1);
        end
        for (i = 0; i < n; i++) begin
            chk("data word", m.data_mem[i], exp_q[i]);
            chk("selection", sel_q[i], rnd ? sel(m.stat_mem[i]) :
                {sw.gain, ch + i[6:0]});
        end
    endtask

    // =================================================================
    // Main sequence and watchdog
    initial begin
        {clk, rst, start, skip, pen, aen, cdone, ovf_seen, brk_d} = '0;
        {acc, cdata, gdly, n_mismatch, checks_done} = '0;
        seed = 59;
        run(1'b0, 3, 7'h7e); // Channel count wraps
        run(1'b1, 3, 7'h05);
        run(1'b0, 1, 7'h00); // Single word overflows at once
        for (k = 0; k < 4; k++) begin
            run(k[0], 2 + ($random(seed) & 3), 7'($random(seed)));
        end
        test_done();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule
